// File: src/frcs_fast_retrain_ctrl_status.sv
// Fast-retrain control and status register for the twisted-pair PHY core.
// Assumes a management register port (address, read and write strobes)
// decoded upstream from the serial management frame, and retrain event
// pulses and capability levels from the PCS, all on ref_clk.
// Counters clear on any read of this register, so a stray debug read
// takes the count away from management software; nothing can undo that.
// The enable bit needs a firmware load after reset to reach its start value.
`timescale 1ns/100ps
`default_nettype none

module frcs_fast_retrain_ctrl_status
    import frcs_pkg::*;
#(
    parameter logic ENABLE_PRELOAD = FRCS_FLAG_RESET
) (
    input  wire logic                   ref_clk,
    input  wire logic                   srst,
    // Management register port
    input  wire logic [4:0]             mgmt_devad,
    input  wire logic [15:0]            mgmt_addr,
    input  wire logic                   mgmt_rd,
    input  wire logic                   mgmt_wr,
    input  wire logic [FRCS_DATA_W-1:0] mgmt_wdata,
    output logic [FRCS_DATA_W-1:0]      mgmt_rdata,
    output logic                        mgmt_rvalid,
    // Firmware preload of the enable bit
    input  wire logic                   fw_enable_load,
    input  wire logic                   fw_enable_value,
    // Retrain events and status from the PCS
    input  wire logic                   partner_retrain_req,
    input  wire logic                   local_retrain_req,
    input  wire logic                   retrain_capable_in,
    input  wire logic                   retrain_agreed_in,
    // Control to the PCS
    output logic                        retrain_enable,
    output logic [1:0]                  retrain_mac_indication
);

    // ==========================================================
    // Address decode
    logic                   devad_hit;
    logic                   addr_hit;
    logic                   reg_hit;
    logic                   rd_hit;
    logic                   wr_hit;

    // Only this one register belongs to the block; other addresses are
    // answered by their own owners, so no response is made here.
    assign devad_hit = (mgmt_devad == FRCS_DEVAD);
    assign addr_hit  = (mgmt_addr == FRCS_REG_ADDR);
    assign reg_hit   = devad_hit && addr_hit;
    assign rd_hit  = mgmt_rd && reg_hit;
    assign wr_hit  = mgmt_wr && reg_hit;

    // ==========================================================
    // Write data fields
    logic [1:0]             wr_ind_field;
    logic                   wr_enable_bit;

    // Sliced once so the indication and enable logic agree on positions
    assign wr_ind_field  = mgmt_wdata[FRCS_IND_MSB:FRCS_IND_LSB];
    assign wr_enable_bit = mgmt_wdata[FRCS_ENABLE_BIT];

    // ==========================================================
    // Status flags
    logic                   retrain_capable;
    logic                   retrain_agreed;

    // Capability level sampled every cycle so a read sees a clean
    // registered value; costs one cycle of latency
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            retrain_capable <= FRCS_FLAG_RESET;
        end else begin
            retrain_capable <= retrain_capable_in;
        end
    end

    // Negotiation result follows the PCS level one cycle late,
    // same as the capability flag so both move together
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            retrain_agreed <= FRCS_FLAG_RESET;
        end else begin
            retrain_agreed <= retrain_agreed_in;
        end
    end

    // ==========================================================
    // Retrain counters
    logic [FRCS_NUM_CH-1:0] ch_req;
    logic [FRCS_NUM_CH-1:0] ch_event;
    logic [FRCS_CNT_W-1:0]  ch_count [FRCS_NUM_CH];
    logic [FRCS_CNT_W-1:0]  partner_retrain_count;
    logic [FRCS_CNT_W-1:0]  local_retrain_count;

    // Request pulses gathered by channel so one loop serves both sources
    assign ch_req[FRCS_CH_PARTNER] = partner_retrain_req;
    assign ch_req[FRCS_CH_LOCAL]   = local_retrain_req;

    // One saturating counter per source, cleared by a read of the register
    generate
        for (genvar ch = 0; ch < FRCS_NUM_CH; ch++) begin : g_cnt
            // Retrains only count while the feature is switched on; a disabled
            // PHY takes the full retrain path and those are not fast retrains.
            assign ch_event[ch] = ch_req[ch] && retrain_enable;

            frcs_sat_counter #(
                .WIDTH (FRCS_CNT_W)
            ) u_cnt (
                .ref_clk (ref_clk),
                .srst    (srst),
                .inc     (ch_event[ch]),
                .clr     (rd_hit),
                .count   (ch_count[ch])
            );
        end
    endgenerate

    // ==========================================================
    // Counter fields
    // Named per source for the register image
    assign partner_retrain_count = ch_count[FRCS_CH_PARTNER];
    assign local_retrain_count   = ch_count[FRCS_CH_LOCAL];

    // ==========================================================
    // Indication select
    logic [1:0]             next_mac_ind;

    // Reserved code is refused: the field keeps its old value, so the PCS
    // never sees an encoding it has no behaviour for.
    always_comb begin
        next_mac_ind = retrain_mac_indication;
        if (wr_hit) begin
            case (wr_ind_field)
                FRCS_IND_IDLE,
                FRCS_IND_LOCAL_FAULT,
                FRCS_IND_LINK_INT: begin
                    next_mac_ind = wr_ind_field;
                end
                default: begin
                    next_mac_ind = retrain_mac_indication;
                end
            endcase
        end
    end

    // Indication register
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            retrain_mac_indication <= FRCS_IND_RESET;
        end else begin
            retrain_mac_indication <= next_mac_ind;
        end
    end

    // ==========================================================
    // Enable bit
    logic                   next_enable;

    // Reset gives a neutral constant; firmware then loads the real start
    // value. A management write in the same cycle wins, being newer intent.
    always_comb begin
        next_enable = retrain_enable;
        if (wr_hit) begin
            next_enable = wr_enable_bit;
        end else if (fw_enable_load) begin
            next_enable = fw_enable_value;
        end
    end

    // Enable register
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            retrain_enable <= ENABLE_PRELOAD;
        end else begin
            retrain_enable <= next_enable;
        end
    end

    // ==========================================================
    // Read data assembly
    logic [FRCS_DATA_W-1:0] reg_image;

    // Reserved bit 5 reads as zero
    always_comb begin
        reg_image = '0;
        reg_image[FRCS_RSVD_BIT]                             = 1'h0;
        reg_image[FRCS_PARTNER_CNT_MSB:FRCS_PARTNER_CNT_LSB] = partner_retrain_count;
        reg_image[FRCS_LOCAL_CNT_MSB:FRCS_LOCAL_CNT_LSB]     = local_retrain_count;
        reg_image[FRCS_CAPABLE_BIT]                          = retrain_capable;
        reg_image[FRCS_AGREED_BIT]                           = retrain_agreed;
        reg_image[FRCS_IND_MSB:FRCS_IND_LSB]                 = retrain_mac_indication;
        reg_image[FRCS_ENABLE_BIT]                           = retrain_enable;
    end

    // Answer strobe: one cycle, the cycle after the read is taken;
    // misses on other addresses leave it low for their owners
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mgmt_rvalid <= 1'b0;
        end else begin
            mgmt_rvalid <= rd_hit;
        end
    end

    // Snapshot taken on the same edge the counters clear, so the value
    // returned is the one that was cleared and nothing falls between.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mgmt_rdata <= '0;
        end else if (rd_hit) begin
            mgmt_rdata <= reg_image;
        end
    end

endmodule

`default_nettype wire

// File: src/frcs_pkg.sv
// Constants for the fast-retrain control and status register bank.
// Assumes one 16-bit management register reached through the device's
// management register port (device address 1).
package frcs_pkg;

    // ==========================================================
    // Register address
    localparam logic [4:0]  FRCS_DEVAD            = 5'h01;
    localparam logic [15:0] FRCS_REG_ADDR         = 16'h0093;
    localparam int          FRCS_DATA_W           = 16;

    // ==========================================================
    // Field positions
    localparam int          FRCS_PARTNER_CNT_MSB  = 15;
    localparam int          FRCS_PARTNER_CNT_LSB  = 11;
    localparam int          FRCS_LOCAL_CNT_MSB    = 10;
    localparam int          FRCS_LOCAL_CNT_LSB    = 6;
    localparam int          FRCS_RSVD_BIT         = 5;
    localparam int          FRCS_CAPABLE_BIT      = 4;
    localparam int          FRCS_AGREED_BIT       = 3;
    localparam int          FRCS_IND_MSB          = 2;
    localparam int          FRCS_IND_LSB          = 1;
    localparam int          FRCS_ENABLE_BIT       = 0;

    // ==========================================================
    // Counter geometry and reset values
    localparam int          FRCS_CNT_W            = 5;
    localparam logic [4:0]  FRCS_CNT_MAX          = 5'h1F;
    localparam logic [4:0]  FRCS_CNT_RESET        = 5'h00;
    localparam logic [1:0]  FRCS_IND_RESET        = 2'h0;
    localparam logic        FRCS_FLAG_RESET       = 1'b0;

    // ==========================================================
    // What the receive PCS shows the MAC during a retrain
    typedef enum logic [1:0] {
        FRCS_IND_IDLE        = 2'b00,
        FRCS_IND_LOCAL_FAULT = 2'b01,
        FRCS_IND_LINK_INT    = 2'b10,
        FRCS_IND_RESERVED    = 2'b11
    } frcs_ind_t;

    // Counter channel indices
    localparam int          FRCS_CH_PARTNER       = 0;
    localparam int          FRCS_CH_LOCAL         = 1;
    localparam int          FRCS_NUM_CH           = 2;

endpackage

// File: src/frcs_sat_counter.sv
// Saturating event counter whose clear still counts an event of the same cycle.
// Assumes events and clear are single-cycle pulses on ref_clk.
`timescale 1ns/100ps
`default_nettype none

module frcs_sat_counter
    import frcs_pkg::*;
#(
    parameter int WIDTH = FRCS_CNT_W
) (
    input  wire logic             ref_clk,
    input  wire logic             srst,
    input  wire logic             inc,
    input  wire logic             clr,
    output logic [WIDTH-1:0]      count
);

    // ==========================================================
    // Next value
    localparam logic [WIDTH-1:0] MAX_VAL = {WIDTH{1'b1}};
    localparam logic [WIDTH-1:0] ONE     = {{(WIDTH-1){1'b0}}, 1'b1};

    logic [WIDTH-1:0] next_count;

    // Clear first, then the event of the same cycle is counted
    always_comb begin
        next_count = count;
        if (clr) begin
            next_count = inc ? ONE : '0;
        end else if (inc && (count != MAX_VAL)) begin
            next_count = count + ONE;
        end
    end

    // ==========================================================
    // Count register
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

endmodule

`default_nettype wire

// File: verif/frcs_remote_phy.sv
// Remote link partner: asks for fast retrains in bursts.
// Assumes the bench pulses start with a burst length, on ref_clk.
`timescale 1ns/100ps
`default_nettype none
module frcs_remote_phy (
    input  wire logic       ref_clk,
    input  wire logic       start,
    input  wire logic [5:0] burst,
    output logic            partner_retrain_req = 1'b0
);
    // ====================
    // Burst engine
    int left = 0;

    // One request a cycle, the most the link can carry
    always @(posedge ref_clk) begin
        partner_retrain_req <= !start && left > 0;
        if (start) begin
            left <= int'(burst);
        end else if (left > 0) begin
            left <= left - 1;
        end
    end
endmodule
`default_nettype wire

// File: verif/frcs_properties.sv
// Checker for the retrain register port.
// Assumes a bind onto the register block, one clock.
`timescale 1ns/100ps
`default_nettype none
module frcs_checker
    import frcs_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        srst,
    input wire logic [4:0]  mgmt_devad,
    input wire logic [15:0] mgmt_addr,
    input wire logic        mgmt_rd,
    input wire logic        mgmt_wr,
    input wire logic [15:0] mgmt_wdata,
    input wire logic [15:0] mgmt_rdata,
    input wire logic        mgmt_rvalid,
    input wire logic        fw_enable_load,
    input wire logic        local_retrain_req,
    input wire logic        retrain_enable,
    input wire logic [1:0]  retrain_mac_indication
);
    // ====================
    // Access decode
    wire logic hit = mgmt_devad == FRCS_DEVAD && mgmt_addr == FRCS_REG_ADDR;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);

    // Reads: clean, or racing a local event
    sequence s_rd; hit && mgmt_rd; endsequence
    sequence s_clean_rd; s_rd ##0 !local_retrain_req; endsequence
    sequence s_race_rd; s_rd ##0 local_retrain_req && retrain_enable; endsequence

    property p_rvalid; s_rd |=> mgmt_rvalid; endproperty
    a_rvalid: assert property (p_rvalid) else $error("read not answered");
    property p_no_rvalid; !(hit && mgmt_rd) |=> !mgmt_rvalid; endproperty
    a_no_rvalid: assert property (p_no_rvalid) else $error("stray read answer");
    property p_clear; s_clean_rd ##1 s_rd |=> mgmt_rdata[10:6] == 5'h00; endproperty
    a_clear: assert property (p_clear) else $error("count not cleared by read");
    property p_race; s_race_rd ##1 s_rd |=> mgmt_rdata[10:6] == 5'h01; endproperty
    a_race: assert property (p_race) else $error("racing event lost");
    property p_ind_wr;
        hit && mgmt_wr && mgmt_wdata[2:1] != 2'h3 |=> retrain_mac_indication == $past(mgmt_wdata[2:1]);
    endproperty
    a_ind_wr: assert property (p_ind_wr) else $error("indication not written");
    property p_ind_hold;
        !(hit && mgmt_wr && mgmt_wdata[2:1] != 2'h3) |=> $stable(retrain_mac_indication);
    endproperty
    a_ind_hold: assert property (p_ind_hold) else $error("indication changed");
    property p_en_wr; hit && mgmt_wr |=> retrain_enable == $past(mgmt_wdata[0]); endproperty
    a_en_wr: assert property (p_en_wr) else $error("enable not written");
    property p_en_hold; !(hit && mgmt_wr) && !fw_enable_load |=> $stable(retrain_enable); endproperty
    a_en_hold: assert property (p_en_hold) else $error("enable changed");
endmodule
bind frcs_fast_retrain_ctrl_status frcs_checker u_chk (.ref_clk, .srst, .mgmt_devad, .mgmt_addr,
    .mgmt_rd, .mgmt_wr, .mgmt_wdata, .mgmt_rdata, .mgmt_rvalid, .fw_enable_load,
    .local_retrain_req, .retrain_enable, .retrain_mac_indication);
`default_nettype wire

// File: verif/tb_fast_retrain_ctrl_status.sv
// Bench for the retrain register: model, stimulus and verdict.
// Assumes the register block, its checker bind and the partner model.
`timescale 1ns/100ps
`default_nettype none
module tb_fast_retrain_ctrl_status;
    import frcs_pkg::*;
    // ====================
    // Signals and model state
    logic        ref_clk = 1'b0, srst = 1'b1, mgmt_rd = 1'b0, mgmt_wr = 1'b0;
    logic        fw_enable_load = 1'b0, fw_enable_value = 1'b0, local_retrain_req = 1'b0;
    logic        cap_in = 1'b0, agr_in = 1'b0, start = 1'b0, partner_req, mgmt_rvalid, retrain_enable;
    logic [5:0]  burst = 6'h00;
    logic [4:0]  mgmt_devad = FRCS_DEVAD;
    logic [15:0] mgmt_addr = FRCS_REG_ADDR, mgmt_wdata = 16'h0000, mgmt_rdata;
    logic [1:0]  ind_out;
    logic [15:0] expq[$];
    int          pc, lc, en, ind, cf, af, cyc, err_total, tests_run;
    wire logic   hit = mgmt_devad == FRCS_DEVAD && mgmt_addr == FRCS_REG_ADDR;

    always #20 ref_clk = ~ref_clk;

    frcs_fast_retrain_ctrl_status dut (.ref_clk, .srst, .mgmt_devad, .mgmt_addr, .mgmt_rd, .mgmt_wr,
        .mgmt_wdata, .mgmt_rdata, .mgmt_rvalid, .fw_enable_load, .fw_enable_value,
        .partner_retrain_req(partner_req), .local_retrain_req, .retrain_capable_in(cap_in),
        .retrain_agreed_in(agr_in), .retrain_enable, .retrain_mac_indication(ind_out));
    frcs_remote_phy u_far (.ref_clk, .start, .burst, .partner_retrain_req(partner_req));

    task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] d);
        mgmt_wr <= wr;
        mgmt_rd <= !wr;
        mgmt_addr <= a;
        mgmt_wdata <= d;
        @(posedge ref_clk);
    endtask
    // Pulses wanted in the next cycle are passed in, so no strobe is assigned twice
    task automatic idle(input logic fw = 1'b0, input logic loc = 1'b0, input logic st = 1'b0);
        {mgmt_rd, mgmt_wr, fw_enable_load, local_retrain_req, start} <= {2'h0, fw, loc, st};
        mgmt_addr <= FRCS_REG_ADDR;
        @(posedge ref_clk);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Reference model; reads capture before the clear, events land after it
    always @(posedge ref_clk) begin
        if (srst) begin
            pc = 0;
            lc = 0;
            en = 0;
            ind = 0;
            cf = 0;
            af = 0;
        end else begin
            if (hit && mgmt_rd) begin
                expq.push_back({5'(pc), 5'(lc), 1'b0, 1'(cf), 1'(af), 2'(ind), 1'(en)});
                pc = 0;
                lc = 0;
            end
            if (partner_req === 1'b1 && en == 1) pc = pc < 31 ? pc + 1 : 31;
            if (local_retrain_req && en == 1) lc = lc < 31 ? lc + 1 : 31;
            if (fw_enable_load) en = fw_enable_value;
            if (hit && mgmt_wr) en = mgmt_wdata[0];
            if (hit && mgmt_wr && mgmt_wdata[2:1] != 2'h3) ind = mgmt_wdata[2:1];
            cf = cap_in;
            af = agr_in;
        end
        cyc++;
        if (cyc == 2000) begin
            err_total++;
            end_of_test();
        end
    end
    // Compare every settled result against the model
    always @(negedge ref_clk) begin
        check("retrain_enable", 16'(en), {15'h0, retrain_enable});
        check("retrain_mac_indication", 16'(ind), {14'h0, ind_out});
        if (mgmt_rvalid !== 1'b0) check("mgmt_rdata", expq.size() > 0 ? expq.pop_front() : 16'hXXXX, mgmt_rdata);
    end

    // ====================
    // Scenarios
    initial begin
        void'($urandom(17));
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        idle();
        acc(1'b0, FRCS_REG_ADDR, 16'h0000);
        fw_enable_value <= 1'b1;
        idle(1'b1);
        for (int k = 0; k < 4; k++) acc(1'b1, FRCS_REG_ADDR, (16'($urandom) & 16'hFFF8) | 16'(k * 2 + 1));
        acc(1'b1, 16'h0094, 16'h0000);
        acc(1'b0, 16'h0094, 16'h0000);
        burst <= 6'h28;
        idle(1'b0, 1'b1, 1'b1);
        start <= 1'b0;
        local_retrain_req <= 1'b1;
        repeat (2) @(posedge ref_clk);
        idle();
        repeat (45) @(posedge ref_clk);
        local_retrain_req <= 1'b1;
        acc(1'b0, FRCS_REG_ADDR, 16'h0000);
        local_retrain_req <= 1'b0;
        acc(1'b0, FRCS_REG_ADDR, 16'h0000);
        acc(1'b0, FRCS_REG_ADDR, 16'h0000);
        acc(1'b1, FRCS_REG_ADDR, 16'h0004);
        burst <= 6'h05;
        idle(1'b0, 1'b1, 1'b1);
        repeat (8) idle();
        for (int k = 0; k < 4; k++) begin
            {cap_in, agr_in} <= 2'($urandom);
            idle();
            acc(1'b0, FRCS_REG_ADDR, 16'h0000);
        end
        srst <= 1'b1;
        repeat (2) idle();
        srst <= 1'b0;
        idle();
        acc(1'b0, FRCS_REG_ADDR, 16'h0000);
        repeat (3) idle();
        check("pending reads", 16'h0000, 16'(expq.size()));
        end_of_test();
    end
endmodule
`default_nettype wire
